// >>> rtl/metpr_pkg.sv
// Package of register map, field layout and timing constants for the event timer and pin router
package metpr_pkg;
   localparam int unsigned NUM_CH = 4;
   localparam int unsigned CH_STRIDE = 16;
   // Register offsets (channel A, route shared); later channels add CH_STRIDE
   localparam logic [7:0] ELAPSED_EVENT_TIME_OFS = 8'h8A;
   localparam logic [7:0] CHANNEL_SOFT_RESET_OFS = 8'h8C;
   localparam logic [7:0] PIN_INTERFACE_ROUTE_OFS = 8'hC0;
   // Designer's own per-channel timer control register
   localparam logic [7:0] TIMER_CONTROL_OFS = 8'h8E;
   localparam logic [15:0] REG_RESET = 16'h0000;
   // Timer control fields
   localparam int unsigned FRAME_MONITOR_ENABLE_BIT = 0;
   localparam int unsigned CARRIER_EDGE_SELECT_LSB = 2;
   localparam int unsigned TIMER_EVENT_SELECT_LSB = 6;
   localparam logic [15:0] TIMER_CONTROL_MASK = 16'h00CD;
   // Channel reset field
   localparam int unsigned CHANNEL_RESET_BIT = 0;
   localparam logic [15:0] CHANNEL_SOFT_RESET_MASK = 16'h0001;
   // Route fields
   localparam int unsigned ROUTE_TARGET_SELECT_LSB = 0;
   localparam int unsigned ROUTE_CHANNEL_SELECT_LSB = 2;
   localparam logic [15:0] PIN_INTERFACE_ROUTE_MASK = 16'h000F;
   localparam logic [1:0] ROUTE_NONE = 2'h0;
   localparam logic [1:0] ROUTE_MODEM = 2'h1;
   localparam logic [1:0] ROUTE_UART = 2'h2;
   localparam logic [1:0] ROUTE_OFF = 2'h3;
   localparam logic [1:0] EVENT_MESSAGE_END = 2'h0;
   localparam logic [1:0] EVENT_MESSAGE_BEGIN = 2'h1;
   localparam logic [1:0] EVENT_TX_COMPLETE = 2'h2;
   localparam logic [1:0] EVENT_CARRIER_EDGE = 2'h3;
   localparam logic [1:0] EDGE_FALL = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_ANY = 2'h2;
   localparam logic [1:0] EDGE_OFF = 2'h3;
   localparam logic [15:0] COUNT_MAX = 16'hFFFF;
   // Time base: phase gains 48 per 100 MHz cycle, ticks on passing 15625, exactly 307.2 kHz
   localparam logic [13:0] TICK_STEP = 14'h0030;
   localparam logic [13:0] TICK_MOD = 14'h3D09;
   localparam int unsigned TICK_W = 14;
   // Pin indices
   localparam int unsigned PIN_A = 0;
   localparam int unsigned PIN_B = 1;
   localparam int unsigned PIN_C = 2;
   localparam int unsigned PIN_D = 3;
   // AXI4-Lite answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> rtl/metpr_pins_if.sv
// Interface of the four shared pins between device and external controller
interface metpr_pins_if;
   logic [3:0] dev_o;
   logic [3:0] dev_oe;
   logic [3:0] ext_o;
   logic [3:0] ext_oe;
   logic [3:0] pin;
   // Wire level: whoever enables drives, device first if both do; otherwise pulled low
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         pin[i] = dev_oe[i] ? dev_o[i] : (ext_oe[i] ? ext_o[i] : 1'b0);
      end
   end
   modport device (output dev_o, output dev_oe, input pin);
   modport controller (output ext_o, output ext_oe, input pin);
endinterface

// >>> rtl/metpr_device.sv
// Device end: per-channel event timers, channel soft resets, pin router, AXI4-Lite slave
// Notes on behaviour
// - Timer counts one per 307.2 kHz tick
// - Selected event starts the timer
// - Saturates at all ones until next event
// - Frame monitor disabled forces timer zero
// - Count read as full 16-bit field
// - Reset bit holds channel paths in reset
// - Software clears reset bit; no self-clear
// - Channel selector 00..11 picks A..D
// - Routing overrides pin and monitor configuration
// - Select 00 or 11 leaves pins unconnected
// - Modem mode disables register path to UART
// - Modem mode: device drives A,B; controller C,D
// - UART mode: controller drives A,B; device C,D
// - UART mode holds modem transmit inputs zero
// - Pins serve one channel at a time
// - Event selector picks end, begin, tx, carrier
// - Carrier edge: fall, rise, any, off
//
// Our own choice: register access over AXI4-Lite.
module metpr_device
   import metpr_pkg::*;
(
   input wire logic aclk, // System clock
   input wire logic aresetn, // Synchronous reset, active low
   input wire logic [7:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Write strobes
   input wire logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   output logic [1:0] s_axi_bresp, // Write response
   output logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [7:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   output logic [31:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   output logic s_axi_rvalid, // Read valid
   input wire logic s_axi_rready, // Read ready
   input wire logic [3:0] modem_cd, // Per-channel modem carrier detect
   input wire logic [3:0] modem_rxd, // Per-channel modem receive data
   input wire logic [3:0] message_end, // Per-channel receive end-of-message pulse
   input wire logic [3:0] message_begin, // Per-channel receive start-of-message pulse
   input wire logic [3:0] tx_complete, // Per-channel transmit complete pulse
   input wire logic [3:0] uart_txd, // Per-channel UART transmit data
   input wire logic [3:0] uart_rts, // Per-channel UART request to send
   output logic [3:0] modem_txd, // Per-channel modem transmit data
   output logic [3:0] modem_rts, // Per-channel modem request to send
   output logic [3:0] uart_cd, // Per-channel carrier detect to UART
   output logic [3:0] uart_rxd, // Per-channel receive data to UART
   output logic [3:0] uart_reg_path_en, // Per-channel register path to UART enabled
   output logic [3:0] channel_in_reset, // Per-channel soft reset of modem, UART, registers
   metpr_pins_if.device pins // Shared pins
);
   import metpr_pkg::*;

   logic [15:0] elapsed_event_count [NUM_CH];
   logic [15:0] timer_control [NUM_CH];
   logic [NUM_CH-1:0] channel_reset_bit;
   logic [1:0] route_target_select;
   logic [1:0] route_channel_select;
   logic [TICK_W-1:0] tick_cnt;
   logic tick;
   logic [2:0] pin_sync [4];
   logic [3:0] pin_in;
   logic [NUM_CH-1:0] cd_prev;
   logic aw_hold, w_hold;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;

   // Decode: returns channel index and register kind
   function automatic logic [3:0] decode(input logic [7:0] a, output logic [1:0] ch);
      logic [7:0] base;
      base = 8'h00;
      ch = 2'h0;
      decode = 4'h0;
      if (a == PIN_INTERFACE_ROUTE_OFS) begin
         decode = 4'h4;
      end else if (a >= 8'h80 && a < 8'hC0) begin
         ch = 2'((a - 8'h80) >> 4);
         base = a - {2'h0, ch, 4'h0};
         if (base == ELAPSED_EVENT_TIME_OFS) decode = 4'h1;
         else if (base == CHANNEL_SOFT_RESET_OFS) decode = 4'h2;
         else if (base == TIMER_CONTROL_OFS) decode = 4'h3;
      end
   endfunction

   // Shared time base
   always_ff @(posedge aclk) begin
      if (!aresetn) tick_cnt <= '0;
      else tick_cnt <= tick_cnt + TICK_STEP - (tick ? TICK_MOD : 14'h0000);
   end
   assign tick = (tick_cnt >= TICK_MOD - TICK_STEP);

   // Pin input synchronisers
   generate
      for (genvar p = 0; p < 4; p++) begin : g_sync
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               pin_sync[p] <= 3'h0;
               pin_in[p] <= 1'b0;
            end else begin
               pin_sync[p] <= {pin_sync[p][1:0], pins.pin[p]};
               if (pin_sync[p][1] == pin_sync[p][2]) pin_in[p] <= pin_sync[p][2];
            end
         end
      end
   endgenerate

   // Per-channel event timers
   generate
      for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
         logic cd_edge, ev;
         logic [1:0] esel, csel;
         always_comb begin
            esel = timer_control[c][TIMER_EVENT_SELECT_LSB +: 2];
            csel = timer_control[c][CARRIER_EDGE_SELECT_LSB +: 2];
            unique case (csel)
               EDGE_FALL: cd_edge = cd_prev[c] && !modem_cd[c];
               EDGE_RISE: cd_edge = !cd_prev[c] && modem_cd[c];
               EDGE_ANY: cd_edge = cd_prev[c] != modem_cd[c];
               EDGE_OFF: cd_edge = 1'b0;
            endcase
            unique case (esel)
               EVENT_MESSAGE_END: ev = message_end[c];
               EVENT_MESSAGE_BEGIN: ev = message_begin[c];
               EVENT_TX_COMPLETE: ev = tx_complete[c];
               EVENT_CARRIER_EDGE: ev = cd_edge;
            endcase
         end
         logic running;
         always_ff @(posedge aclk) begin
            if (!aresetn || channel_reset_bit[c]) begin
               elapsed_event_count[c] <= REG_RESET;
               running <= 1'b0;
               cd_prev[c] <= modem_cd[c]; // No false edge after reset
            end else begin
               cd_prev[c] <= modem_cd[c];
               if (!timer_control[c][FRAME_MONITOR_ENABLE_BIT]) begin
                  elapsed_event_count[c] <= REG_RESET;
                  running <= 1'b0;
               end else if (ev) begin
                  elapsed_event_count[c] <= REG_RESET;
                  running <= 1'b1;
               end else if (running && tick && elapsed_event_count[c] != COUNT_MAX) begin
                  elapsed_event_count[c] <= elapsed_event_count[c] + 16'h0001;
               end
            end
         end
      end
   endgenerate

   // Register writes and AXI write channel
   always_ff @(posedge aclk) begin
      logic [3:0] kind;
      logic [1:0] ch;
      if (!aresetn) begin
         aw_hold <= 1'b0;
         w_hold <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bresp <= RESP_OKAY;
         channel_reset_bit <= '0;
         route_target_select <= ROUTE_NONE;
         route_channel_select <= 2'h0;
         for (int i = 0; i < NUM_CH; i++) timer_control[i] <= REG_RESET;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         s_axi_awready <= !(s_axi_awvalid && s_axi_awready) && (s_axi_awready || (s_axi_bvalid && s_axi_bready));
         s_axi_wready <= !(s_axi_wvalid && s_axi_wready) && (s_axi_wready || (s_axi_bvalid && s_axi_bready));
         if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
         if (aw_hold && w_hold && !s_axi_bvalid) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            s_axi_bvalid <= 1'b1;
            kind = decode(aw_addr, ch);
            s_axi_bresp <= (kind == 4'h0) ? RESP_SLVERR : RESP_OKAY; // Exact address match, data in bits 15:0
            if (w_strb[0]) begin
               unique case (kind)
                  4'h2: channel_reset_bit[ch] <= w_data[CHANNEL_RESET_BIT];
                  4'h3: timer_control[ch] <= w_data[15:0] & TIMER_CONTROL_MASK;
                  4'h4: begin
                     route_target_select <= w_data[ROUTE_TARGET_SELECT_LSB +: 2];
                     route_channel_select <= w_data[ROUTE_CHANNEL_SELECT_LSB +: 2];
                  end
                  default: ;
               endcase
            end
         end
      end
   end

   // AXI read channel
   always_ff @(posedge aclk) begin
      logic [3:0] kind;
      logic [1:0] ch;
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
         s_axi_arready <= 1'b0;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
         if (s_axi_rvalid && s_axi_rready) s_axi_rvalid <= 1'b0;
         if (s_axi_arvalid && s_axi_arready) begin
            kind = decode(s_axi_araddr, ch);
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= (kind == 4'h0) ? RESP_SLVERR : RESP_OKAY;
            unique case (kind)
               4'h1: s_axi_rdata <= {16'h0000, elapsed_event_count[ch]};
               4'h2: s_axi_rdata <= {31'h0, channel_reset_bit[ch]};
               4'h3: s_axi_rdata <= {16'h0000, timer_control[ch]};
               4'h4: s_axi_rdata <= {28'h0, route_channel_select, route_target_select};
               default: s_axi_rdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Pin router; all outputs registered
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pins.dev_o <= 4'h0;
         pins.dev_oe <= 4'h0;
         modem_txd <= 4'h0;
         modem_rts <= 4'h0;
         uart_cd <= 4'h0;
         uart_rxd <= 4'h0;
         uart_reg_path_en <= 4'hF;
         channel_in_reset <= 4'h0;
      end else begin
         channel_in_reset <= channel_reset_bit;
         pins.dev_o <= 4'h0;
         pins.dev_oe <= 4'h0;
         uart_reg_path_en <= 4'hF;
         modem_txd <= 4'h0;
         modem_rts <= 4'h0;
         uart_cd <= 4'h0;
         uart_rxd <= 4'h0;
         if (route_target_select == ROUTE_MODEM) begin
            uart_reg_path_en[route_channel_select] <= 1'b0;
            pins.dev_oe[PIN_A] <= 1'b1;
            pins.dev_oe[PIN_B] <= 1'b1;
            pins.dev_o[PIN_A] <= modem_cd[route_channel_select];
            pins.dev_o[PIN_B] <= modem_rxd[route_channel_select];
            modem_txd[route_channel_select] <= pin_in[PIN_C];
            modem_rts[route_channel_select] <= pin_in[PIN_D];
         end else if (route_target_select == ROUTE_UART) begin
            pins.dev_oe[PIN_C] <= 1'b1;
            pins.dev_oe[PIN_D] <= 1'b1;
            pins.dev_o[PIN_C] <= uart_txd[route_channel_select];
            pins.dev_o[PIN_D] <= uart_rts[route_channel_select];
            uart_cd[route_channel_select] <= pin_in[PIN_A];
            uart_rxd[route_channel_select] <= pin_in[PIN_B];
            // Modem transmit inputs stay zero in this mode
         end
      end
   end
endmodule

// >>> rtl/metpr_controller.sv
// External controller end: drives and samples the four shared pins per routing mode
module metpr_controller
   import metpr_pkg::*;
(
   input wire logic aclk, // System clock
   input wire logic aresetn, // Synchronous reset, active low
   input wire logic [1:0] mode, // Routing mode expected on the device
   input wire logic ctl_txd, // Transmit data toward modem
   input wire logic ctl_rts, // Request to send toward modem
   input wire logic ctl_cd, // Carrier detect toward UART
   input wire logic ctl_rxd, // Receive data toward UART
   output logic [3:0] pin_seen, // Synchronised pin levels
   metpr_pins_if.controller pins // Shared pins
);
   import metpr_pkg::*;

   logic [2:0] sync [4];

   generate
      for (genvar p = 0; p < 4; p++) begin : g_sync
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               sync[p] <= 3'h0;
               pin_seen[p] <= 1'b0;
            end else begin
               sync[p] <= {sync[p][1:0], pins.pin[p]};
               if (sync[p][1] == sync[p][2]) pin_seen[p] <= sync[p][2];
            end
         end
      end
   endgenerate

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pins.ext_o <= 4'h0;
         pins.ext_oe <= 4'h0;
      end else begin
         pins.ext_o <= 4'h0;
         pins.ext_oe <= 4'h0;
         if (mode == ROUTE_MODEM) begin
            pins.ext_oe <= 4'hC;
            pins.ext_o[PIN_C] <= ctl_txd;
            pins.ext_o[PIN_D] <= ctl_rts;
         end else if (mode == ROUTE_UART) begin
            pins.ext_oe <= 4'h3;
            pins.ext_o[PIN_A] <= ctl_cd;
            pins.ext_o[PIN_B] <= ctl_rxd;
         end
      end
   end
endmodule

// >>> sim/metpr_checker.sv
// Checker of the shared pin wire between device and controller
module metpr_checker (
   input wire logic aclk, // Clock
   input wire logic aresetn, // Sync reset, active low
   input wire logic [3:0] dev_o, // Device pin data
   input wire logic [3:0] dev_oe, // Device pin enables
   input wire logic [3:0] ext_o, // Controller pin data
   input wire logic [3:0] ext_oe, // Controller pin enables
   input wire logic [3:0] pin // Wire levels
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   chk_no_contention: assert property ((dev_oe & ext_oe) == 4'h0)
      else $error("device and controller drive one pin");
   chk_device_pairs: assert property (dev_oe inside {4'h0, 4'h3, 4'hC})
      else $error("device enables outside a routing pattern");
   chk_ctl_pairs: assert property (ext_oe inside {4'h0, 4'h3, 4'hC})
      else $error("controller enables outside a routing pattern");
   chk_modem_pair: assert property (dev_oe == 4'h3 && ext_oe != 4'h0 |-> ext_oe == 4'hC)
      else $error("modem routing with wrong controller pins");
   chk_idle_low: assert property (dev_oe == 4'h0 && ext_oe == 4'h0 |-> pin == 4'h0)
      else $error("undriven pins not low");
   chk_reset_quiet: assert property ($rose(aresetn) |-> (dev_o | dev_oe | ext_o | ext_oe) == 4'h0)
      else $error("pins driven right after reset");
   cover property (dev_oe == 4'h3 && ext_oe == 4'hC);
   cover property (dev_oe == 4'hC && ext_oe == 4'h3);
   cover property ($fell(|dev_oe));
endmodule

// >>> sim/testbench.sv
// Self-checking bench: device and controller joined by the pin interface
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import metpr_pkg::*;
   typedef struct packed {
      logic [1:0] tgt;
      logic [1:0] ch;
      logic [3:0] ctl;
      logic [3:0] pins;
      logic [7:0] mdm;
      logic [7:0] urt;
      logic [3:0] path;
   } metpr_row_t;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb, modem_cd, modem_rxd, message_end, message_begin, tx_complete, uart_txd, uart_rts;
   logic [3:0] modem_txd, modem_rts, uart_cd, uart_rxd, uart_reg_path_en, channel_in_reset, pin_seen;
   logic [1:0] bresp, rresp, ctl_mode;
   logic ctl_txd, ctl_rts, ctl_cd, ctl_rxd;
   int n_errors = 0;
   int checked = 0;
   // Modem and UART per-channel inputs are fixed at A, 5, 6, 9
   metpr_row_t rows[7] = '{'{2'h1, 2'h0, 4'h8, 4'h6, 8'h10, 8'h00, 4'hE},
      '{2'h1, 2'h3, 4'h4, 4'h9, 8'h08, 8'h00, 4'h7}, '{2'h1, 2'h1, 4'hF, 4'hD, 8'h22, 8'h00, 4'hD},
      '{2'h2, 2'h2, 4'hE, 4'h5, 8'h00, 8'h40, 4'hF}, '{2'h2, 2'h3, 4'h3, 4'hB, 8'h00, 8'h88, 4'hF},
      '{2'h0, 2'h1, 4'hF, 4'h0, 8'h00, 8'h00, 4'hF}, '{2'h3, 2'h2, 4'hF, 4'h0, 8'h00, 8'h00, 4'hF}};
   metpr_pins_if pins_if ();
   metpr_device u_metpr_device (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .modem_cd(modem_cd), .modem_rxd(modem_rxd),
      .message_end(message_end), .message_begin(message_begin), .tx_complete(tx_complete), .uart_txd(uart_txd),
      .uart_rts(uart_rts), .modem_txd(modem_txd), .modem_rts(modem_rts), .uart_cd(uart_cd), .uart_rxd(uart_rxd),
      .uart_reg_path_en(uart_reg_path_en), .channel_in_reset(channel_in_reset), .pins(pins_if));
   metpr_controller u_metpr_controller (.aclk(aclk), .aresetn(aresetn), .mode(ctl_mode), .ctl_txd(ctl_txd),
      .ctl_rts(ctl_rts), .ctl_cd(ctl_cd), .ctl_rxd(ctl_rxd), .pin_seen(pin_seen), .pins(pins_if));
   metpr_checker u_chk (.aclk(aclk), .aresetn(aresetn), .dev_o(pins_if.dev_o), .dev_oe(pins_if.dev_oe),
      .ext_o(pins_if.ext_o), .ext_oe(pins_if.ext_oe), .pin(pins_if.pin));
   task automatic give_verdict;
      if (n_errors == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk_port(input string what, input logic [3:0] exp, input logic [3:0] got);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk_bus(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Ends just after an edge, outputs settled
   task automatic settle(input int n);
      repeat (n) @(posedge aclk);
      #1;
   endtask
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
      logic aw_t, w_t, b_seen;
      logic [1:0] resp;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      b_seen = 1'b0;
      while (!b_seen) begin
         #1;
         aw_t = awvalid && awready;
         w_t = wvalid && wready;
         b_seen = bvalid;
         resp = bresp;
         @(posedge aclk);
         if (aw_t) awvalid <= 1'b0;
         if (w_t) wvalid <= 1'b0;
      end
      bready <= 1'b0;
      chk_bus("bresp", {30'h0, er}, {30'h0, resp});
   endtask
   task automatic axi_fetch(input logic [7:0] a, output logic [31:0] data, output logic [1:0] resp);
      logic ar_t, r_seen;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      r_seen = 1'b0;
      while (!r_seen) begin
         #1;
         ar_t = arvalid && arready;
         r_seen = rvalid;
         data = rdata;
         resp = rresp;
         @(posedge aclk);
         if (ar_t) arvalid <= 1'b0;
      end
      rready <= 1'b0;
   endtask
   task automatic chk_span(input string what, input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] got);
      checked++;
      if ($isunknown(got) || got < lo || got > hi) begin
         n_errors++;
         $display("wrong value %s expected %h to %h seen %h", what, lo, hi, got);
      end
   endtask
   task automatic axi_read(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
      logic [31:0] data;
      logic [1:0] resp;
      axi_fetch(a, data, resp);
      chk_bus("rresp", {30'h0, er}, {30'h0, resp});
      chk_bus("rdata", exp, data);
   endtask
   task automatic read_span(input logic [7:0] a, input logic [31:0] lo, input logic [31:0] hi);
      logic [31:0] data;
      logic [1:0] resp;
      axi_fetch(a, data, resp);
      chk_bus("rresp", {30'h0, RESP_OKAY}, {30'h0, resp});
      chk_span("rdata", lo, hi, data);
   endtask
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   initial begin
      repeat (20000) @(posedge aclk);
      n_errors++;
      give_verdict;
   end
   initial begin
      aresetn = 1'b0;
      {awaddr, araddr, wdata, wstrb, awvalid, wvalid, bready, arvalid, rready} = '0;
      {message_end, message_begin, tx_complete, ctl_mode, ctl_txd, ctl_rts, ctl_cd, ctl_rxd} = '0;
      modem_cd = 4'hA;
      modem_rxd = 4'h5;
      uart_txd = 4'h6;
      uart_rts = 4'h9;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      settle(1);
      chk_port("channel_in_reset", 4'h0, channel_in_reset);
      chk_port("uart_reg_path_en", 4'hF, uart_reg_path_en);
      axi_read(PIN_INTERFACE_ROUTE_OFS, 32'h0, RESP_OKAY);
      axi_read(CHANNEL_SOFT_RESET_OFS, 32'h0, RESP_OKAY);
      foreach (rows[i]) begin
         ctl_mode <= ROUTE_NONE;
         axi_write(PIN_INTERFACE_ROUTE_OFS, 32'h0, 4'hF, RESP_OKAY);
         axi_write(PIN_INTERFACE_ROUTE_OFS, {28'h0, rows[i].ch, rows[i].tgt}, 4'hF, RESP_OKAY);
         {ctl_txd, ctl_rts, ctl_cd, ctl_rxd} <= rows[i].ctl;
         ctl_mode <= rows[i].tgt;
         settle(12);
         chk_port("pin_seen", rows[i].pins, pin_seen);
         chk_port("modem_txd", rows[i].mdm[7:4], modem_txd);
         chk_port("modem_rts", rows[i].mdm[3:0], modem_rts);
         chk_port("uart_cd", rows[i].urt[7:4], uart_cd);
         chk_port("uart_rxd", rows[i].urt[3:0], uart_rxd);
         chk_port("uart_reg_path_en", rows[i].path, uart_reg_path_en);
         axi_read(PIN_INTERFACE_ROUTE_OFS, {28'h0, rows[i].ch, rows[i].tgt}, RESP_OKAY);
      end
      for (int n = 0; n < 4; n++) begin
         axi_write(CHANNEL_SOFT_RESET_OFS + 8'(16 * n), 32'hFFFF_0001, 4'hF, RESP_OKAY);
         settle(2);
         chk_port("channel_in_reset", 4'((2 << n) - 1), channel_in_reset);
      end
      axi_write(8'h9C, 32'h0, 4'h0, RESP_OKAY);
      axi_write(8'h90, 32'h0, 4'hF, RESP_SLVERR);
      settle(50);
      chk_port("channel_in_reset", 4'hF, channel_in_reset);
      axi_read(8'hBC, 32'h1, RESP_OKAY);
      for (int n = 0; n < 4; n++) begin
         axi_write(CHANNEL_SOFT_RESET_OFS + 8'(16 * n), 32'h0, 4'hF, RESP_OKAY);
      end
      settle(2);
      chk_port("channel_in_reset", 4'h0, channel_in_reset);
      {message_end, message_begin, tx_complete} <= 12'hFFF;
      settle(1);
      {message_end, message_begin, tx_complete} <= 12'h000;
      modem_cd <= 4'h5;
      axi_read(ELAPSED_EVENT_TIME_OFS, 32'h0, RESP_OKAY);
      // Channel A timer: start on message end, restart on message begin
      axi_write(TIMER_CONTROL_OFS, 32'h0000_0001, 4'hF, RESP_OKAY);
      message_end <= 4'h1;
      settle(1);
      message_end <= 4'h0;
      settle(1000);
      read_span(ELAPSED_EVENT_TIME_OFS, 32'h0000_0003, 32'h0000_0004);
      axi_write(TIMER_CONTROL_OFS, 32'h0000_0041, 4'hF, RESP_OKAY);
      message_begin <= 4'h1;
      settle(1);
      message_begin <= 4'h0;
      settle(1000);
      read_span(ELAPSED_EVENT_TIME_OFS, 32'h0000_0003, 32'h0000_0004);
      axi_write(TIMER_CONTROL_OFS, 32'h0000_00C4, 4'hF, RESP_OKAY);
      axi_read(ELAPSED_EVENT_TIME_OFS, 32'h0, RESP_OKAY);
      axi_write(TIMER_CONTROL_OFS, 32'h0000_00C5, 4'hF, RESP_OKAY);
      modem_cd <= 4'h4;
      settle(400);
      axi_read(ELAPSED_EVENT_TIME_OFS, 32'h0, RESP_OKAY);
      modem_cd <= 4'h5;
      settle(1000);
      read_span(ELAPSED_EVENT_TIME_OFS, 32'h0000_0003, 32'h0000_0004);
      axi_write(CHANNEL_SOFT_RESET_OFS, 32'h1, 4'hF, RESP_OKAY);
      axi_read(ELAPSED_EVENT_TIME_OFS, 32'h0, RESP_OKAY);
      axi_write(CHANNEL_SOFT_RESET_OFS, 32'h0, 4'hF, RESP_OKAY);
      axi_write(PIN_INTERFACE_ROUTE_OFS, 32'h1, 4'hF, RESP_OKAY);
      ctl_mode <= ROUTE_MODEM;
      axi_write(8'h9C, 32'h1, 4'hF, RESP_OKAY);
      settle(12);
      aresetn <= 1'b0;
      ctl_mode <= ROUTE_NONE;
      settle(3);
      aresetn <= 1'b1;
      settle(1);
      chk_port("channel_in_reset", 4'h0, channel_in_reset);
      chk_port("uart_reg_path_en", 4'hF, uart_reg_path_en);
      chk_port("modem_txd", 4'h0, modem_txd);
      axi_read(PIN_INTERFACE_ROUTE_OFS, 32'h0, RESP_OKAY);
      give_verdict;
   end
endmodule
